// ==== src/cvod_object_dictionary.sv ====
`timescale 1ns/1ps
`include "cvod_map.svh"

// How it works
// - Device type reads zero, other sub aborts
// - Error register always reads zero
// - Heartbeat time readable, frames at 700h+node
// - Identity has four entries incl revision
// - SDO request 600h+node, answer 580h+node
// - Receive PDO parameters: 200h+node, type FEh
// - Receive PDO maps command, clear, command bits
// - Transmit PDO parameters: 180h+node, type 1
// - Transmit PDO byte order fixed
// - Positions unsigned 16-bit, low byte first
// - Temperature byte, minus 40 offset
// - Overall status byte layout
// - Input fault byte layout
// - System fault byte layout
// - Position command taken only from CAN source
// - Fault when command timeout elapses
// - Supply voltage read-only 16-bit
// - Coil current demand read-only 16-bit
// - Analog and pulse readbacks use position scaling
// - Status data byte packing
// - Extra values only via SDO
// - Only first four receive PDO bytes used
module cvod_object_dictionary #(
  parameter int          MS_CYCLES    = `CVOD_MS_CYCLES,
  parameter logic [31:0] VENDOR_ID    = 32'h0000_0A5A, // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_1111, // Arbitrary value
  parameter logic [31:0] REVISION     = 32'h0000_0001
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [6:0]  node_id_i,
  input  wire logic [31:0] serial_i,
  input  wire logic [15:0] heartbeat_ms_i,
  input  wire logic [13:0] timeout_ms_i,
  input  wire logic [1:0]  demand_src_i,
  input  wire logic        pdo_enable_i,
  input  wire logic [7:0]  nmt_state_i,
  input  wire logic [15:0] act_pos_i,
  input  wire logic [15:0] des_pos_i,
  input  wire logic [7:0]  temp_i,
  input  wire logic [5:0]  ovr_status_i,
  input  wire logic [7:0]  input_fault_i,
  input  wire logic [4:0]  sys_fault_i,
  input  wire logic [15:0] supply_volt_i,
  input  wire logic [15:0] coil_cur_i,
  input  wire logic [15:0] analog_cmd_i,
  input  wire logic [15:0] pulse_cmd_i,
  input  wire logic [3:0]  op_status_i,
  input  wire logic        dout_i,
  input  wire logic [2:0]  demand_state_i,
  input  wire logic        rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic [3:0]  rx_dlc_i,
  input  wire logic [63:0] rx_data_i,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic [10:0]      tx_id_o,
  output logic [3:0]       tx_dlc_o,
  output logic [63:0]      tx_data_o,
  output logic [15:0]      pos_cmd_o,
  output logic [7:0]       clear_diag_o,
  output logic [7:0]       cmd_bits_o,
  output logic             can_fault_o
);

  generate
    if (MS_CYCLES < 1 || MS_CYCLES > (1 << 20)) begin : g_bad_ms
      $error("MS_CYCLES out of range");
    end
  endgenerate

  cvod_pkg::cvod_state_t s_reg;
  cvod_pkg::cvod_state_t s_next;

  logic [10:0] node11;
  logic        sdo_req;
  logic        pdo_rx;
  logic [15:0] idx;
  logic [7:0]  sub;
  logic        sub0;
  logic [2:0]  ccs;
  logic        rd_ok;
  logic [31:0] rd_val;
  logic [1:0]  rd_len;
  logic [31:0] rd_ab;
  logic        wr_obj;
  logic        cmd_hit;
  logic [15:0] cmd_val;
  logic        ms;
  logic [7:0]  stat1;
  logic [7:0]  stat3;
  logic        launch_pdo;

  always_comb begin
    s_next = s_reg;
    node11 = {4'h0, node_id_i};
    sdo_req = rx_valid_i && (rx_id_i == 11'(`CVOD_COB_SDORX + node11));
    pdo_rx = rx_valid_i && (rx_id_i == 11'(`CVOD_COB_RPDO + node11));
    idx = rx_data_i[23:8];
    sub = rx_data_i[31:24];
    sub0 = (sub == 8'h00);
    ccs = rx_data_i[7:5];
    stat1 = {1'b0, temp_i > 8'(`CVOD_TEMP_HOT_C + `CVOD_TEMP_OFFSET),
             ovr_status_i};
    stat3 = {3'b000, sys_fault_i[4] | s_reg.can_fault, sys_fault_i[3:0]};
    rd_ok = 1'b0;
    rd_val = 32'h0000_0000;
    rd_len = `CVOD_LEN1;
    rd_ab = `CVOD_AB_SUB;
    // Read lookup
    case (idx)
      `CVOD_IDX_DEVTYPE: begin
        rd_ok = sub0;
        rd_val = `CVOD_DEVTYPE_VAL;
        rd_len = `CVOD_LEN4;
      end
      `CVOD_IDX_ERRREG: begin
        rd_ok = sub0;
        rd_val = {24'h0, `CVOD_ERRREG_VAL};
      end
      `CVOD_IDX_HBTIME: begin
        rd_ok = sub0;
        rd_val = {16'h0, heartbeat_ms_i};
        rd_len = `CVOD_LEN2;
      end
      `CVOD_IDX_IDENT: begin
        rd_ok = (sub <= `CVOD_IDENT_CNT);
        rd_len = sub0 ? `CVOD_LEN1 : `CVOD_LEN4;
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_IDENT_CNT};
          8'h01: rd_val = VENDOR_ID;
          8'h02: rd_val = PRODUCT_CODE;
          8'h03: rd_val = REVISION;
          default: rd_val = serial_i;
        endcase
      end
      `CVOD_IDX_SDOPAR: begin
        rd_ok = (sub <= `CVOD_SDOPAR_CNT);
        rd_len = sub0 ? `CVOD_LEN1 : `CVOD_LEN4;
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_SDOPAR_CNT};
          8'h01: rd_val = {21'h0, 11'(`CVOD_COB_SDORX + node11)};
          default: rd_val = {21'h0, 11'(`CVOD_COB_SDOTX + node11)};
        endcase
      end
      `CVOD_IDX_RPDOPAR: begin
        rd_ok = (sub <= `CVOD_RPDOPAR_CNT);
        rd_len = (sub == 8'h01) ? `CVOD_LEN4 : `CVOD_LEN1;
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_RPDOPAR_CNT};
          8'h01: rd_val = {21'h0, 11'(`CVOD_COB_RPDO + node11)};
          default: rd_val = {24'h0, `CVOD_RPDO_TTYPE};
        endcase
      end
      `CVOD_IDX_RPDOMAP: begin
        rd_ok = (sub <= `CVOD_RPDOMAP_CNT);
        rd_len = sub0 ? `CVOD_LEN1 : `CVOD_LEN4;
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_RPDOMAP_CNT};
          8'h01: rd_val = `CVOD_MAP_POSCMD;
          8'h02: rd_val = `CVOD_MAP_CLRDIAG;
          default: rd_val = `CVOD_MAP_CMDBITS;
        endcase
      end
      `CVOD_IDX_TPDOPAR: begin
        rd_ok = (sub <= 8'h02) || (sub == `CVOD_TPDOPAR_MAX);
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_TPDOPAR_MAX};
          8'h01: begin
            rd_val = {21'h0, 11'(`CVOD_COB_TPDO + node11)};
            rd_len = `CVOD_LEN4;
          end
          8'h02: rd_val = {24'h0, `CVOD_TPDO_TTYPE};
          default: begin
            rd_val = {16'h0, `CVOD_TPDO_EVTMR};
            rd_len = `CVOD_LEN2;
          end
        endcase
      end
      `CVOD_IDX_TPDOMAP: begin
        rd_ok = (sub <= `CVOD_TPDOMAP_CNT);
        rd_len = sub0 ? `CVOD_LEN1 : `CVOD_LEN4;
        case (sub)
          8'h00: rd_val = {24'h0, `CVOD_TPDOMAP_CNT};
          8'h01: rd_val = `CVOD_MAP_ACTPOS;
          8'h02: rd_val = `CVOD_MAP_DESPOS;
          8'h03: rd_val = `CVOD_MAP_TEMP;
          8'h04: rd_val = `CVOD_MAP_STAT1;
          8'h05: rd_val = `CVOD_MAP_STAT2;
          default: rd_val = `CVOD_MAP_STAT3;
        endcase
      end
      `CVOD_IDX_ACTPOS, `CVOD_IDX_DESPOS, `CVOD_IDX_VOLT, `CVOD_IDX_CURR,
      `CVOD_IDX_ANACMD, `CVOD_IDX_PWMCMD, `CVOD_IDX_BUSCMD: begin
        rd_ok = sub0;
        rd_len = `CVOD_LEN2;
        case (idx)
          `CVOD_IDX_ACTPOS: rd_val = {16'h0, act_pos_i};
          `CVOD_IDX_DESPOS: rd_val = {16'h0, des_pos_i};
          `CVOD_IDX_VOLT: rd_val = {16'h0, supply_volt_i};
          `CVOD_IDX_CURR: rd_val = {16'h0, coil_cur_i};
          `CVOD_IDX_ANACMD: rd_val = {16'h0, analog_cmd_i};
          `CVOD_IDX_PWMCMD: rd_val = {16'h0, pulse_cmd_i};
          default: rd_val = {16'h0, s_reg.bus_cmd};
        endcase
      end
      `CVOD_IDX_TEMP, `CVOD_IDX_STAT1, `CVOD_IDX_STAT2, `CVOD_IDX_STAT3,
      `CVOD_IDX_STATDATA: begin
        rd_ok = sub0;
        case (idx)
          `CVOD_IDX_TEMP: rd_val = {24'h0, temp_i};
          `CVOD_IDX_STAT1: rd_val = {24'h0, stat1};
          `CVOD_IDX_STAT2: rd_val = {24'h0, input_fault_i};
          `CVOD_IDX_STAT3: rd_val = {24'h0, stat3};
          default: rd_val = {24'h0, demand_state_i, dout_i, op_status_i};
        endcase
      end
      `CVOD_IDX_POSCMD, `CVOD_IDX_CLRDIAG, `CVOD_IDX_CMDBITS: begin
        rd_ab = sub0 ? `CVOD_AB_WO : `CVOD_AB_SUB;
      end
      default: rd_ab = `CVOD_AB_NOOBJ;
    endcase
    wr_obj = sub0 && (idx == `CVOD_IDX_POSCMD || idx == `CVOD_IDX_CLRDIAG ||
                      idx == `CVOD_IDX_CMDBITS);

    // Frame launch: SDO answer first, then transmit PDO, then heartbeat
    launch_pdo = 1'b0;
    if (s_reg.tx_valid && tx_ready_i) begin
      s_next.tx_valid = 1'b0;
    end
    if (!s_next.tx_valid) begin
      if (s_reg.sdo_pend) begin
        s_next.tx_valid = 1'b1;
        s_next.tx_id = 11'(`CVOD_COB_SDOTX + node11);
        s_next.tx_dlc = 4'h8;
        s_next.tx_data = s_reg.sdo_data;
        s_next.sdo_pend = 1'b0;
      end else if (s_reg.pdo_pend) begin
        launch_pdo = 1'b1;
        s_next.tx_valid = 1'b1;
        s_next.tx_id = 11'(`CVOD_COB_TPDO + node11);
        s_next.tx_dlc = 4'h8;
        s_next.tx_data = {stat3, input_fault_i, stat1, temp_i,
                          des_pos_i, act_pos_i};
        s_next.pdo_pend = 1'b0;
      end else if (s_reg.hb_pend) begin
        s_next.tx_valid = 1'b1;
        s_next.tx_id = 11'(`CVOD_COB_HB + node11);
        s_next.tx_dlc = 4'h1;
        s_next.tx_data = {56'h0, nmt_state_i};
        s_next.hb_pend = 1'b0;
      end
    end

    // SDO answer, built when the request arrives
    if (sdo_req) begin
      s_next.sdo_pend = 1'b1;
      if (ccs == `CVOD_CCS_UP && rd_ok) begin
        s_next.sdo_data = {rd_val, rx_data_i[31:8],
                           `CVOD_SCS_UP | {4'h0, rd_len, 2'b00}};
      end else if (ccs == `CVOD_CCS_DOWN && wr_obj) begin
        s_next.sdo_data = {32'h0, rx_data_i[31:8], `CVOD_SCS_DOWN};
      end else if (ccs == `CVOD_CCS_UP) begin
        s_next.sdo_data = {rd_ab, rx_data_i[31:8], `CVOD_SCS_ABORT};
      end else if (ccs == `CVOD_CCS_DOWN) begin
        s_next.sdo_data = {rd_ok ? `CVOD_AB_RO : rd_ab,
                           rx_data_i[31:8],
                           `CVOD_SCS_ABORT};
      end else begin
        s_next.sdo_data = {`CVOD_AB_CMD, rx_data_i[31:8], `CVOD_SCS_ABORT};
      end
    end

    // Incoming commands; receive PDO bytes past the fourth are never looked at
    cmd_hit = (pdo_rx && rx_dlc_i >= 4'h2) ||
              (sdo_req && ccs == `CVOD_CCS_DOWN && idx == `CVOD_IDX_POSCMD && sub0);
    cmd_val = pdo_rx ? rx_data_i[15:0] : rx_data_i[47:32];
    if (pdo_rx && rx_dlc_i >= 4'h3) begin
      s_next.clr_diag = rx_data_i[23:16];
    end else if (sdo_req && ccs == `CVOD_CCS_DOWN && idx == `CVOD_IDX_CLRDIAG && sub0) begin
      s_next.clr_diag = rx_data_i[39:32];
    end
    if (pdo_rx && rx_dlc_i >= 4'h4) begin
      s_next.cmd_bits = rx_data_i[31:24];
    end else if (sdo_req && ccs == `CVOD_CCS_DOWN && idx == `CVOD_IDX_CMDBITS && sub0) begin
      s_next.cmd_bits = rx_data_i[39:32];
    end

    // Millisecond timebase and timers
    ms = (s_reg.presc == 20'(MS_CYCLES - 1));
    s_next.presc = ms ? 20'h00000 : 20'(s_reg.presc + 20'h00001);
    if (ms) begin
      s_next.tp_cnt = (s_reg.tp_cnt == 7'(`CVOD_TPDO_MS - 7'h01)) ?
                      7'h00 : 7'(s_reg.tp_cnt + 7'h01);
      if (s_reg.tp_cnt == 7'(`CVOD_TPDO_MS - 7'h01) && pdo_enable_i) begin
        s_next.pdo_pend = 1'b1;
      end
      if (heartbeat_ms_i == 16'h0000) begin
        s_next.hb_cnt = 16'h0000;
      end else if (16'(s_reg.hb_cnt + 16'h0001) >= heartbeat_ms_i) begin
        s_next.hb_cnt = 16'h0000;
        s_next.hb_pend = 1'b1;
      end else begin
        s_next.hb_cnt = 16'(s_reg.hb_cnt + 16'h0001);
      end
      if (!s_reg.to_fault) begin
        s_next.to_cnt = 14'(s_reg.to_cnt + 14'h0001);
        if (14'(s_reg.to_cnt + 14'h0001) >= timeout_ms_i) begin
          s_next.to_fault = 1'b1;
        end
      end
    end
    if (demand_src_i != `CVOD_SRC_CAN) begin
      s_next.to_cnt = 14'h0000;
      s_next.to_fault = 1'b0;
    end else if (cmd_hit) begin
      s_next.bus_cmd = cmd_val;
      s_next.to_cnt = 14'h0000;
      s_next.to_fault = 1'b0;
      s_next.dmd_fault = (cmd_val > `CVOD_POS_MAX);
      s_next.rng_err = (cmd_val > `CVOD_POS_FULL) && (cmd_val <= `CVOD_POS_MAX);
      if (cmd_val > `CVOD_POS_MAX) begin
        s_next.pos_cmd = 16'h0000;
      end else if (cmd_val > `CVOD_POS_FULL) begin
        s_next.pos_cmd = `CVOD_POS_FULL;
      end else begin
        s_next.pos_cmd = cmd_val;
      end
    end
    s_next.can_fault = s_next.to_fault | s_next.dmd_fault | s_next.rng_err;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx_valid_o = s_reg.tx_valid;
  assign tx_id_o = s_reg.tx_id;
  assign tx_dlc_o = s_reg.tx_dlc;
  assign tx_data_o = s_reg.tx_data;
  assign pos_cmd_o = s_reg.pos_cmd;
  assign clear_diag_o = s_reg.clr_diag;
  assign cmd_bits_o = s_reg.cmd_bits;
  assign can_fault_o = s_reg.can_fault;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_read(logic [15:0] i, logic [7:0] sb);
    sdo_req && ccs == `CVOD_CCS_UP && idx == i && sub == sb;
  endsequence

  property p_devtype;
    s_read(`CVOD_IDX_DEVTYPE, 8'h00) |=>
      s_reg.sdo_pend && s_reg.sdo_data[7:0] == 8'h43 && s_reg.sdo_data[63:32] == 32'h0;
  endproperty
  a_devtype: assert property (p_devtype) else $error("device type not zero");

  property p_subabort;
    sdo_req && ccs == `CVOD_CCS_UP && idx == `CVOD_IDX_DEVTYPE && !sub0 |=>
      s_reg.sdo_data[7:0] == 8'h80 && s_reg.sdo_data[63:32] == 32'h0609_0011;
  endproperty
  a_subabort: assert property (p_subabort) else $error("missing sub abort");

  property p_errreg;
    s_read(`CVOD_IDX_ERRREG, 8'h00) |=>
      s_reg.sdo_data[7:0] == 8'h4F && s_reg.sdo_data[39:32] == 8'h00;
  endproperty
  a_errreg: assert property (p_errreg) else $error("error register not zero");

  property p_txid;
    tx_valid_o |-> tx_id_o == 11'(11'h580 + node11) || tx_id_o == 11'(11'h180 + node11) ||
                   tx_id_o == 11'(11'h700 + node11);
  endproperty
  a_txid: assert property (p_txid) else $error("bad transmit identifier");

  property p_hbframe;
    tx_valid_o && tx_id_o == 11'(11'h700 + node11) |-> tx_dlc_o == 4'h1;
  endproperty
  a_hbframe: assert property (p_hbframe) else $error("bad heartbeat frame");

  property p_tpdo;
    launch_pdo |=> tx_valid_o && tx_dlc_o == 4'h8 && tx_data_o[15:0] == $past(act_pos_i)
                   && tx_data_o[39:32] == $past(temp_i);
  endproperty
  a_tpdo: assert property (p_tpdo) else $error("transmit PDO layout wrong");

  property p_notcan;
    pdo_rx && demand_src_i != 2'h2 |=> $stable(pos_cmd_o);
  endproperty
  a_notcan: assert property (p_notcan) else $error("command taken from non-CAN source");

  property p_limit;
    pos_cmd_o <= 16'h9C40;
  endproperty
  a_limit: assert property (p_limit) else $error("position command above full");

  property p_fresh;
    pdo_rx && rx_dlc_i >= 4'h2 && demand_src_i == 2'h2 && rx_data_i[15:0] <= 16'h9C40
      |=> !can_fault_o ##1 !can_fault_o;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fault after fresh command");

  property p_woread;
    s_read(`CVOD_IDX_POSCMD, 8'h00) |=>
      s_reg.sdo_data[7:0] == 8'h80 && s_reg.sdo_data[63:32] == 32'h0601_0001;
  endproperty
  a_woread: assert property (p_woread) else $error("write-only read not aborted");

endmodule // cvod_object_dictionary

// ==== src/cvod_map.svh ====
`ifndef CVOD_MAP_SVH
`define CVOD_MAP_SVH

// Object indexes
`define CVOD_IDX_DEVTYPE  16'h1000
`define CVOD_IDX_ERRREG   16'h1001
`define CVOD_IDX_HBTIME   16'h1017
`define CVOD_IDX_IDENT    16'h1018
`define CVOD_IDX_SDOPAR   16'h1200
`define CVOD_IDX_RPDOPAR  16'h1400
`define CVOD_IDX_RPDOMAP  16'h1600
`define CVOD_IDX_TPDOPAR  16'h1800
`define CVOD_IDX_TPDOMAP  16'h1A00
`define CVOD_IDX_ACTPOS   16'h2210
`define CVOD_IDX_DESPOS   16'h2211
`define CVOD_IDX_TEMP     16'h2212
`define CVOD_IDX_STAT1    16'h2213
`define CVOD_IDX_STAT2    16'h2214
`define CVOD_IDX_STAT3    16'h2215
`define CVOD_IDX_POSCMD   16'h2216
`define CVOD_IDX_VOLT     16'h2219
`define CVOD_IDX_CURR     16'h221A
`define CVOD_IDX_ANACMD   16'h221B
`define CVOD_IDX_PWMCMD   16'h221C
`define CVOD_IDX_BUSCMD   16'h221D
`define CVOD_IDX_CLRDIAG  16'h221F
`define CVOD_IDX_CMDBITS  16'h2220
`define CVOD_IDX_STATDATA 16'h2221

// Identifier bases
`define CVOD_COB_TPDO  11'h180
`define CVOD_COB_RPDO  11'h200
`define CVOD_COB_SDOTX 11'h580
`define CVOD_COB_SDORX 11'h600
`define CVOD_COB_HB    11'h700

// Object contents
`define CVOD_DEVTYPE_VAL  32'h0000_0000
`define CVOD_ERRREG_VAL   8'h00
`define CVOD_IDENT_CNT    8'h04
`define CVOD_SDOPAR_CNT   8'h02
`define CVOD_RPDOPAR_CNT  8'h02
`define CVOD_RPDO_TTYPE   8'hFE
`define CVOD_RPDOMAP_CNT  8'h03
`define CVOD_TPDOPAR_MAX  8'h05
`define CVOD_TPDO_TTYPE   8'h01
`define CVOD_TPDO_EVTMR   16'h0000
`define CVOD_TPDOMAP_CNT  8'h06
`define CVOD_MAP_POSCMD   32'h2216_0010
`define CVOD_MAP_CLRDIAG  32'h221F_0008
`define CVOD_MAP_CMDBITS  32'h2220_0008
`define CVOD_MAP_ACTPOS   32'h2210_0010
`define CVOD_MAP_DESPOS   32'h2211_0010
`define CVOD_MAP_TEMP     32'h2212_0008
`define CVOD_MAP_STAT1    32'h2213_0008
`define CVOD_MAP_STAT2    32'h2214_0008
`define CVOD_MAP_STAT3    32'h2215_0008

// SDO command bytes and abort codes
`define CVOD_CCS_DOWN     3'h1
`define CVOD_CCS_UP       3'h2
`define CVOD_SCS_UP       8'h43
`define CVOD_SCS_DOWN     8'h60
`define CVOD_SCS_ABORT    8'h80
`define CVOD_LEN4         2'h0
`define CVOD_LEN2         2'h2
`define CVOD_LEN1         2'h3
`define CVOD_AB_SUB       32'h0609_0011
`define CVOD_AB_NOOBJ     32'h0602_0000
`define CVOD_AB_RO        32'h0601_0002
`define CVOD_AB_WO        32'h0601_0001
`define CVOD_AB_CMD       32'h0504_0001

// Scaling limits
`define CVOD_POS_FULL     16'h9C40
`define CVOD_POS_MAX      16'hFAFF
`define CVOD_TEMP_OFFSET  8'h28
`define CVOD_TEMP_HOT_C   8'h7D
`define CVOD_SRC_CAN      2'h2

// Timing
`define CVOD_CLK_PERIOD_NS 4
`define CVOD_MS_NS         1000000
`define CVOD_MS_CYCLES     (`CVOD_MS_NS / `CVOD_CLK_PERIOD_NS)
`define CVOD_TPDO_MS       7'h60

`endif

// ==== src/cvod_pkg.sv ====
package cvod_pkg;

  typedef struct packed {
    logic        tx_valid;
    logic [10:0] tx_id;
    logic [3:0]  tx_dlc;
    logic [63:0] tx_data;
    logic        sdo_pend;
    logic [63:0] sdo_data;
    logic        pdo_pend;
    logic        hb_pend;
    logic [15:0] pos_cmd;
    logic [15:0] bus_cmd;
    logic [7:0]  clr_diag;
    logic [7:0]  cmd_bits;
    logic        rng_err;
    logic        dmd_fault;
    logic        to_fault;
    logic        can_fault;
    logic [19:0] presc;
    logic [13:0] to_cnt;
    logic [15:0] hb_cnt;
    logic [6:0]  tp_cnt;
  } cvod_state_t;

endpackage

// ==== tb/cvod_can_master.sv ====
`timescale 1ns/1ps
module cvod_can_master (
  input  wire logic        clk_sys_i,
  input  wire logic        slow_i,
  output logic             rx_valid_o,
  output logic [10:0]      rx_id_o,
  output logic [3:0]       rx_dlc_o,
  output logic [63:0]      rx_data_o,
  output logic             tx_ready_o
);
  logic [1:0] stall_reg = 2'h0;
  initial begin
    rx_valid_o = 1'b0;
    rx_id_o = 11'h000;
    rx_dlc_o = 4'h0;
    rx_data_o = 64'h0;
  end
  always @(posedge clk_sys_i) stall_reg <= stall_reg + 2'h1;
  // Prompt, or one cycle in four when stalling
  assign tx_ready_o = !slow_i || (stall_reg == 2'h3);
  // One frame; released lines show the inverse
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_dlc_o <= dlc;
    rx_data_o <= d;
    @(posedge clk_sys_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_dlc_o <= ~dlc;
    rx_data_o <= ~d;
  endtask
endmodule // cvod_can_master

// ==== tb/tb_cvod_object_dictionary.sv ====
`timescale 1ns/1ps
module tb_cvod_object_dictionary;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        slow = 1'b0;
  logic        pdo_enable_i = 1'b1;
  logic        dout_i = 1'b1;
  logic [6:0]  node_id_i = 7'h05;
  logic [31:0] serial_i = 32'h00C0FFEE;
  logic [15:0] heartbeat_ms_i = 16'h0003;
  logic [13:0] timeout_ms_i = 14'h00C8;
  logic [1:0]  demand_src_i = 2'h2;
  logic [7:0]  nmt_state_i = 8'h05, temp_i = 8'hA6, input_fault_i = 8'hC3;
  logic [15:0] act_pos_i = 16'h1234, des_pos_i = 16'h9C40, supply_volt_i = 16'h04D2;
  logic [15:0] coil_cur_i = 16'h7D7F, analog_cmd_i = 16'h2345, pulse_cmd_i = 16'h3456;
  logic [5:0]  ovr_status_i = 6'h2A;
  logic [4:0]  sys_fault_i = 5'h0B;
  logic [3:0]  op_status_i = 4'h3, rx_dlc_i, tx_dlc_o, dl;
  logic [2:0]  demand_state_i = 3'h5;
  logic        rx_valid_i, tx_ready_i, tx_valid_o, can_fault_o;
  logic [10:0] rx_id_i, tx_id_o;
  logic [63:0] rx_data_i, tx_data_o, r;
  logic [15:0] pos_cmd_o;
  logic [7:0]  clear_diag_o, cmd_bits_o;
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;

  cvod_object_dictionary #(.MS_CYCLES(10)) uut (.*);
  cvod_can_master u_master (.clk_sys_i(clk_sys_i), .slow_i(slow), .rx_valid_o(rx_valid_i),
    .rx_id_o(rx_id_i), .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));

  initial forever #2 clk_sys_i = ~clk_sys_i;

  task automatic close_out();
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic wait_frame(input logic [10:0] id);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!(tx_valid_o === 1'b1 && tx_ready_i === 1'b1 && tx_id_o === id) && n < 3000);
    r = tx_data_o;
    dl = tx_dlc_o;
    if (n >= 3000) failures++;
  endtask

  task automatic sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] v);
    u_master.send(11'h600 + {4'h0, node_id_i}, 4'h8, {v, s, i, c});
    wait_frame(11'h580 + {4'h0, node_id_i});
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input int w,
                    input logic [31:0] e);
    logic [31:0] m;
    logic [7:0]  b;
    m = (w == 4) ? 32'hFFFFFFFF : (w == 2) ? 32'h0000FFFF : 32'h000000FF;
    b = (w == 4) ? 8'h43 : (w == 2) ? 8'h4B : 8'h4F;
    sdo(8'h40, i, s, 32'h0);
    chk({r[63:32] & m, r[31:0], 4'h0, dl}, {e, s, i, b, 8'h08});
  endtask

  task automatic ab(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
                    input logic [31:0] e);
    sdo(c, i, s, 32'h0);
    chk(r, {e, s, i, 8'h80});
  endtask

  task automatic pdo(input logic [3:0] n, input logic [63:0] d, input logic [63:0] e);
    u_master.send(11'h200 + {4'h0, node_id_i}, n, d);
    @(posedge clk_sys_i);
    chk({pos_cmd_o, clear_diag_o, cmd_bits_o, can_fault_o}, e);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    pdo(4'h8, 64'hDEADBEEF_0201_9C41, {16'h9C40, 16'h0102, 1'b1});
    pdo(4'h4, 64'h00000000_0403_FB00, {16'h0000, 16'h0304, 1'b1});
    pdo(4'h2, 64'hFFFFFFFF_FFFF_9C40, {16'h9C40, 16'h0304, 1'b0});
    demand_src_i <= 2'h1;
    pdo(4'h2, 64'h0000_1111, {16'h9C40, 16'h0304, 1'b0});
    demand_src_i <= 2'h2;
    rd(16'h1000, 8'h00, 4, 32'h0);
    ab(8'h40, 16'h1000, 8'h01, 32'h06090011);
    rd(16'h1001, 8'h00, 1, 32'h0);
    rd(16'h1017, 8'h00, 2, 32'h3);
    rd(16'h1018, 8'h00, 1, 32'h4);
    rd(16'h1018, 8'h03, 4, 32'h1);
    rd(16'h1018, 8'h04, 4, serial_i);
    rd(16'h1200, 8'h01, 4, 32'h605);
    rd(16'h1200, 8'h02, 4, 32'h585);
    temp_i <= 8'hA5;
    rd(16'h2213, 8'h00, 1, 32'h2A);
    temp_i <= 8'hA6;
    rd(16'h2214, 8'h00, 1, 32'hC3);
    rd(16'h2215, 8'h00, 1, 32'h0B);
    slow <= 1'b1;
    rd(16'h1400, 8'h00, 1, 32'h2);
    rd(16'h1400, 8'h01, 4, 32'h205);
    rd(16'h1400, 8'h02, 1, 32'hFE);
    rd(16'h1600, 8'h01, 4, 32'h22160010);
    rd(16'h1600, 8'h02, 4, 32'h221F0008);
    rd(16'h1600, 8'h03, 4, 32'h22200008);
    rd(16'h1800, 8'h00, 1, 32'h5);
    rd(16'h1800, 8'h01, 4, 32'h185);
    rd(16'h1800, 8'h02, 1, 32'h1);
    rd(16'h1800, 8'h05, 2, 32'h0);
    rd(16'h2219, 8'h00, 2, 32'h04D2);
    rd(16'h221A, 8'h00, 2, 32'h7D7F);
    rd(16'h221B, 8'h00, 2, 32'h2345);
    rd(16'h221C, 8'h00, 2, 32'h3456);
    rd(16'h221D, 8'h00, 2, 32'h9C40);
    rd(16'h2221, 8'h00, 1, 32'hB3);
    ab(8'h2B, 16'h2210, 8'h00, 32'h06010002);
    ab(8'h40, 16'h2216, 8'h00, 32'h06010001);
    ab(8'h40, 16'h3000, 8'h00, 32'h06020000);
    sdo(8'h2B, 16'h2216, 8'h00, 32'h1000);
    chk({r[31:0], pos_cmd_o}, {32'h00221660, 16'h1000});
    slow <= 1'b0;
    pdo(4'h2, 64'h1000, {16'h1000, 16'h0304, 1'b0});
    wait_frame(11'h185);
    chk(r, 64'h0B_C3_6A_A6_9C40_1234);
    chk(dl, 4'h8);
    wait_frame(11'h705);
    chk({dl, r[7:0]}, {4'h1, 8'h05});
    timeout_ms_i <= 14'h0003;
    pdo(4'h2, 64'h2000, {16'h2000, 16'h0304, 1'b0});
    repeat (15) @(posedge clk_sys_i);
    chk(can_fault_o, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    chk(can_fault_o, 1'b1);
    pdo(4'h2, 64'h2000, {16'h2000, 16'h0304, 1'b0});
    sdo(8'h2F, 16'h221F, 8'h00, 32'h55);
    sdo(8'h2F, 16'h2220, 8'h00, 32'hAA);
    chk({r[31:0], clear_diag_o, cmd_bits_o}, {32'h00222060, 16'h55AA});
    ab(8'hE0, 16'h1000, 8'h00, 32'h05040001);
    close_out();
  end
endmodule // tb_cvod_object_dictionary
